/* File: rtl/pwl_pkg.sv */
package pwl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the APB
    localparam int          ADDR_W    = 12;
    localparam logic [11:0] OFS_WAKE  = 12'h000;
    localparam logic [11:0] OFS_LV    = 12'h004;
    localparam logic [11:0] OFS_STS   = 12'h008;
    localparam logic [11:0] OFS_MASK  = 12'h00C;

    ////////////////////////////////////////////////////////////////////////
    // Wakeup register fields
    localparam int WK_FLAG_BIT = 7;
    localparam int WK_ACK_BIT  = 6;
    localparam int WK_CLKS_BIT = 5;
    localparam int WK_IE_BIT   = 4;
    localparam int WK_PER_LSB  = 0;
    localparam int WK_PER_W    = 3;

    // Low-voltage register fields
    localparam int LV_FLAG_BIT = 7;
    localparam int LV_ACK_BIT  = 6;
    localparam int LV_IE_BIT   = 5;
    localparam int LV_RE_BIT   = 4;
    localparam int LV_SE_BIT   = 3;
    localparam int LV_DE_BIT   = 2;

    // Interrupt status and mask fields
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_LV_BIT   = 1;
    localparam int IRQ_W        = 2;

    ////////////////////////////////////////////////////////////////////////
    // Timing: internal oscillator tick and timer width
    localparam int SYS_CLK_NS      = 20;
    localparam int INT_TICK_NS     = 1_150_000;
    localparam int INT_TICK_CYCLES = INT_TICK_NS / SYS_CLK_NS;
    localparam int CNT_W           = 15;

    ////////////////////////////////////////////////////////////////////////
    // Control carriers and reset values
    typedef struct packed {
        logic                clk_sel;
        logic                irq_en;
        logic [WK_PER_W-1:0] period;
    } pwl_wake_ctrl_t;

    typedef struct packed {
        logic irq_en;
        logic reset_en;
        logic stop_en;
        logic detect_en;
    } pwl_lv_ctrl_t;

    localparam pwl_wake_ctrl_t   WAKE_CTRL_RST = 5'h00;
    localparam pwl_lv_ctrl_t     LV_CTRL_RST   = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST  = 2'h0;

endpackage : pwl_pkg

/* File: rtl/pwl_wakeup_timer.sv */
`timescale 1ns/100ps
module pwl_wakeup_timer #(
    parameter int CNT_W = pwl_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    // Tick enables and control
    input  wire logic                    int_tick_in,
    input  wire logic                    ext_tick_in,
    input  wire logic                    restart_in,
    input  wire pwl_pkg::pwl_wake_ctrl_t ctrl_in,
    // Timeout pulse
    output logic                         timeout_out
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] lim_m1;
    logic             tick;
    logic             off;

    // Terminal count from source and period code
    always_comb begin
        off  = ctrl_in.clk_sel && (ctrl_in.period == 3'h0);
        tick = ctrl_in.clk_sel ? ext_tick_in : int_tick_in;
        if (!ctrl_in.clk_sel) begin
            lim_m1 = CNT_W'((16'h0008 << ctrl_in.period) - 16'h0001);
        end else if (ctrl_in.period == 3'h1) begin
            lim_m1 = CNT_W'(16'h00FF);
        end else begin
            lim_m1 = CNT_W'((16'h0400 << (ctrl_in.period - 3'h2)) - 16'h0001);
        end
    end

    // Period counter, cleared on reload so a shorter period cannot overshoot
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
        end else if (restart_in || off) begin
            cnt_reg <= '0;
        end else if (tick) begin
            cnt_reg <= (cnt_reg == lim_m1) ? '0 : cnt_reg + 1'b1;
        end
    end

    // One-cycle timeout pulse
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timeout_out <= 1'b0;
        end else begin
            timeout_out <= tick && !restart_in && !off && (cnt_reg == lim_m1);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_ext_disabled: assert property (off |=> !timeout_out)
        else $error("timeout while external source disabled");
    chk_period_hit: assert property (timeout_out |-> $past(cnt_reg == lim_m1 && tick))
        else $error("timeout before terminal count");
    chk_restart_zero: assert property (restart_in |=> cnt_reg == '0)
        else $error("counter not cleared on reload");

endmodule : pwl_wakeup_timer

/* File: rtl/pwl_lowvolt.sv */
`timescale 1ns/100ps
module pwl_lowvolt (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    // Comparator, mode and control
    input  wire logic                  below_in,
    input  wire logic                  stop_mode_in,
    input  wire logic                  ack_in,
    input  wire pwl_pkg::pwl_lv_ctrl_t ctrl_in,
    // Flag state
    output logic                       flag_out,
    output logic                       flag_next_out,
    output logic                       active_out
);

    // Detection runs only when enabled, and in stop only if allowed
    always_comb begin
        active_out    = ctrl_in.detect_en && (!stop_mode_in || ctrl_in.stop_en);
        flag_next_out = flag_out;
        if (active_out && below_in) begin
            flag_next_out = 1'b1;
        end else if (ack_in) begin
            flag_next_out = 1'b0;
        end
    end

    // Sticky flag; a new event beats a same-cycle acknowledge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_out <= 1'b0;
        end else begin
            flag_out <= flag_next_out;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_flag_set: assert property (active_out && below_in |=> flag_out)
        else $error("low-voltage flag not set");
    chk_ack_clear: assert property (ack_in && !(active_out && below_in) |=> !flag_out)
        else $error("acknowledge did not clear flag");
    chk_stop_gate: assert property (stop_mode_in && !ctrl_in.stop_en |-> !active_out)
        else $error("detection active in stop");
    chk_off_quiet: assert property (!ctrl_in.detect_en && !flag_out |=> !flag_out)
        else $error("flag set while detection off");

endmodule : pwl_lowvolt

/* File: rtl/pwl_top.sv */
// Functional notes
// - Wakeup flag, bit 7 read-only, sets when the timer ends its period.
// - Writing 1 to bit 6 clears the wakeup flag; bit 6 reads 0.
// - Bit 5 picks timer clock: 0 internal oscillator, 1 external clock.
// - Bit 4 enables wakeup interrupt requests.
// - Internal source: 8 to 1024 ticks of a 1.15 ms oscillator.
// - External source with period code zero disables the timer.
// - External source codes 1..7 give 256 to 32768 clock periods.
// - Period field bits 2:0, read/write, steers the timer period.
// - Low-voltage flag bit 7 sets when supply is below threshold, if enabled.
// - Writing 1 to bit 6 clears the low-voltage flag; bit reads 0.
// - Bit 5 makes a set low-voltage flag raise an interrupt request.
// - Bit 4 with detection on makes a set flag force chip reset.
// - Bit 3 keeps detection running in stop mode.
// - Bit 2 switches detection logic on; other behaviour needs it.
// - Write-once bits take only the first write after reset.
`timescale 1ns/100ps
module pwl_top #(
    parameter int INT_TICK_CYCLES = pwl_pkg::INT_TICK_CYCLES,
    parameter int CNT_W           = pwl_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic                       sys_clk_in,
    input  wire logic                       nrst_in,

    // APB slave
    input  wire logic [pwl_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [31:0]                pwdata_in,
    input  wire logic [3:0]                 pstrb_in,
    output logic      [31:0]                prdata_out,
    output logic                            pready_out,
    output logic                            pslverr_out,

    // Analog and clock-source pins
    input  wire logic                       ext_clk_in,
    input  wire logic                       lv_below_in,

    // Power mode from system logic
    input  wire logic                       stop_mode_in,

    // Requests and controls
    output logic                            wakeup_irq_out,
    output logic                            lowvolt_irq_out,
    output logic                            chip_reset_out,
    output logic                            lv_sense_en_out,
    output logic                            irq_out
);

    localparam int DIV_W = $clog2(INT_TICK_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic                          rst_s1_reg;
    logic                          rst_n_sync;
    logic                          ext_s1_reg;
    logic                          ext_s2_reg;
    logic                          ext_s3_reg;
    logic                          lv_s1_reg;
    logic                          lv_s2_reg;
    logic [DIV_W-1:0]              div_reg;
    logic                          int_tick_reg;
    logic                          ext_tick;

    logic                          setup_ph;
    logic                          access_ok;
    logic                          mapped;
    logic                          wr_wake;
    logic                          wr_lv;
    logic                          wr_sts;
    logic                          wr_mask;
    logic [31:0]                   rdata;

    pwl_pkg::pwl_wake_ctrl_t       wake_ctrl_reg;
    pwl_pkg::pwl_wake_ctrl_t       wake_ctrl_next;
    pwl_pkg::pwl_lv_ctrl_t         lv_ctrl_reg;
    pwl_pkg::pwl_lv_ctrl_t         lv_ctrl_next;
    logic                          lv_locked_reg;
    logic                          wake_flag_reg;
    logic                          wake_flag_next;
    logic                          timeout;
    logic                          lv_ack;
    logic                          lv_flag;
    logic                          lv_flag_next;
    logic                          lv_active;

    logic [pwl_pkg::IRQ_W-1:0]     sts_reg;
    logic [pwl_pkg::IRQ_W-1:0]     sts_next;
    logic [pwl_pkg::IRQ_W-1:0]     mask_reg;
    logic [pwl_pkg::IRQ_W-1:0]     evt;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_s1_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_sync <= rst_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; third flop only for edge detect
    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            lv_s1_reg  <= 1'b0;
            lv_s2_reg  <= 1'b0;
        end else begin
            ext_s1_reg <= ext_clk_in;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            lv_s1_reg  <= lv_below_in;
            lv_s2_reg  <= lv_s1_reg;
        end
    end

    // External clock must stay well below sys_clk/2 to be counted
    assign ext_tick = ext_s2_reg && !ext_s3_reg;

    ////////////////////////////////////////////////////////////////////////
    // Internal oscillator stand-in: free divider, never reloaded by software
    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            div_reg      <= '0;
            int_tick_reg <= 1'b0;
        end else if (div_reg == DIV_W'(INT_TICK_CYCLES - 1)) begin
            div_reg      <= '0;
            int_tick_reg <= 1'b1;
        end else begin
            div_reg      <= div_reg + 1'b1;
            int_tick_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero-wait access, writes land at the access edge
    always_comb begin
        setup_ph  = psel_in && !penable_in;
        access_ok = psel_in && penable_in && pready_out && !pslverr_out;
        mapped    = (paddr_in == pwl_pkg::OFS_WAKE) || (paddr_in == pwl_pkg::OFS_LV) ||
                    (paddr_in == pwl_pkg::OFS_STS) || (paddr_in == pwl_pkg::OFS_MASK);
        wr_wake   = access_ok && pwrite_in && pstrb_in[0] && (paddr_in == pwl_pkg::OFS_WAKE);
        wr_lv     = access_ok && pwrite_in && pstrb_in[0] && (paddr_in == pwl_pkg::OFS_LV);
        wr_sts    = access_ok && pwrite_in && pstrb_in[0] && (paddr_in == pwl_pkg::OFS_STS);
        wr_mask   = access_ok && pwrite_in && pstrb_in[0] && (paddr_in == pwl_pkg::OFS_MASK);
    end

    // Read mux; acknowledge bits and unused bits read zero
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (paddr_in)
            pwl_pkg::OFS_WAKE: begin
                rdata[pwl_pkg::WK_FLAG_BIT] = wake_flag_reg;
                rdata[pwl_pkg::WK_CLKS_BIT] = wake_ctrl_reg.clk_sel;
                rdata[pwl_pkg::WK_IE_BIT]   = wake_ctrl_reg.irq_en;
                rdata[pwl_pkg::WK_PER_LSB +: pwl_pkg::WK_PER_W] = wake_ctrl_reg.period;
            end
            pwl_pkg::OFS_LV: begin
                rdata[pwl_pkg::LV_FLAG_BIT] = lv_flag;
                rdata[pwl_pkg::LV_IE_BIT]   = lv_ctrl_reg.irq_en;
                rdata[pwl_pkg::LV_RE_BIT]   = lv_ctrl_reg.reset_en;
                rdata[pwl_pkg::LV_SE_BIT]   = lv_ctrl_reg.stop_en;
                rdata[pwl_pkg::LV_DE_BIT]   = lv_ctrl_reg.detect_en;
            end
            pwl_pkg::OFS_STS: begin
                rdata[pwl_pkg::IRQ_W-1:0] = sts_reg;
            end
            pwl_pkg::OFS_MASK: begin
                rdata[pwl_pkg::IRQ_W-1:0] = mask_reg;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    // Answer registers, loaded in the setup cycle
    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= setup_ph;
            pslverr_out <= setup_ph && !mapped;
            prdata_out  <= (setup_ph && !pwrite_in) ? rdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wakeup control and flag next values
    always_comb begin
        wake_ctrl_next = wake_ctrl_reg;
        if (wr_wake) begin
            wake_ctrl_next.clk_sel = pwdata_in[pwl_pkg::WK_CLKS_BIT];
            wake_ctrl_next.irq_en  = pwdata_in[pwl_pkg::WK_IE_BIT];
            wake_ctrl_next.period  = pwdata_in[pwl_pkg::WK_PER_LSB +: pwl_pkg::WK_PER_W];
        end
        wake_flag_next = wake_flag_reg;
        if (timeout) begin
            wake_flag_next = 1'b1;
        end else if (wr_wake && pwdata_in[pwl_pkg::WK_ACK_BIT]) begin
            wake_flag_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            wake_ctrl_reg <= pwl_pkg::WAKE_CTRL_RST;
            wake_flag_reg <= 1'b0;
        end else begin
            wake_ctrl_reg <= wake_ctrl_next;
            wake_flag_reg <= wake_flag_next;
        end
    end

    // Timer sees the stored control; a write reloads it
    pwl_wakeup_timer #(
        .CNT_W       (CNT_W)
    ) u_timer (
        .clk_in      (sys_clk_in),
        .rst_n_in    (rst_n_sync),
        .int_tick_in (int_tick_reg),
        .ext_tick_in (ext_tick),
        .restart_in  (wr_wake),
        .ctrl_in     (wake_ctrl_reg),
        .timeout_out (timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // Low-voltage control; reset, stop and detect enables are write-once
    always_comb begin
        lv_ctrl_next = lv_ctrl_reg;
        if (wr_lv) begin
            lv_ctrl_next.irq_en = pwdata_in[pwl_pkg::LV_IE_BIT];
            if (!lv_locked_reg) begin
                lv_ctrl_next.reset_en  = pwdata_in[pwl_pkg::LV_RE_BIT];
                lv_ctrl_next.stop_en   = pwdata_in[pwl_pkg::LV_SE_BIT];
                lv_ctrl_next.detect_en = pwdata_in[pwl_pkg::LV_DE_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            lv_ctrl_reg   <= pwl_pkg::LV_CTRL_RST;
            lv_locked_reg <= 1'b0;
        end else begin
            lv_ctrl_reg   <= lv_ctrl_next;
            lv_locked_reg <= lv_locked_reg || wr_lv;
        end
    end

    assign lv_ack = wr_lv && pwdata_in[pwl_pkg::LV_ACK_BIT];

    pwl_lowvolt u_lowvolt (
        .clk_in        (sys_clk_in),
        .rst_n_in      (rst_n_sync),
        .below_in      (lv_s2_reg),
        .stop_mode_in  (stop_mode_in),
        .ack_in        (lv_ack),
        .ctrl_in       (lv_ctrl_reg),
        .flag_out      (lv_flag),
        .flag_next_out (lv_flag_next),
        .active_out    (lv_active)
    );

    ////////////////////////////////////////////////////////////////////////
    // Request outputs from next values, so they track the flags exactly
    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            wakeup_irq_out  <= 1'b0;
            lowvolt_irq_out <= 1'b0;
            chip_reset_out  <= 1'b0;
            lv_sense_en_out <= 1'b0;
        end else begin
            wakeup_irq_out  <= wake_flag_next && wake_ctrl_next.irq_en;
            lowvolt_irq_out <= lv_flag_next && lv_ctrl_next.irq_en;
            chip_reset_out  <= lv_flag_next && lv_ctrl_next.reset_en &&
                               lv_ctrl_next.detect_en;
            lv_sense_en_out <= lv_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status, write one to clear; set wins
    assign evt[pwl_pkg::IRQ_WAKE_BIT] = timeout;
    assign evt[pwl_pkg::IRQ_LV_BIT]   = lv_flag_next && !lv_flag;

    always_comb begin
        sts_next = sts_reg;
        if (wr_sts) begin
            sts_next = sts_reg & ~pwdata_in[pwl_pkg::IRQ_W-1:0];
        end
        sts_next = sts_next | evt;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            sts_reg  <= '0;
            mask_reg <= pwl_pkg::IRQ_MASK_RST;
            irq_out  <= 1'b0;
        end else begin
            sts_reg  <= sts_next;
            mask_reg <= wr_mask ? pwdata_in[pwl_pkg::IRQ_W-1:0] : mask_reg;
            irq_out  <= |(sts_next & (wr_mask ? pwdata_in[pwl_pkg::IRQ_W-1:0] : mask_reg));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_sync);

    sequence s_wr_wake;
        psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0] &&
        (paddr_in == pwl_pkg::OFS_WAKE);
    endsequence

    sequence s_wr_lv;
        psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0] &&
        (paddr_in == pwl_pkg::OFS_LV);
    endsequence

    chk_wake_set: assert property (timeout |=> wake_flag_reg)
        else $error("timeout did not set wakeup flag");
    chk_wake_ack: assert property (s_wr_wake ##0 pwdata_in[6] && !timeout |=> !wake_flag_reg)
        else $error("wakeup acknowledge failed");
    chk_period_store: assert property (s_wr_wake |=> wake_ctrl_reg.period == $past(pwdata_in[2:0]))
        else $error("period field not stored");
    chk_wake_irq: assert property (wake_flag_reg && wake_ctrl_reg.irq_en |-> wakeup_irq_out)
        else $error("wakeup request missing");
    chk_wake_mask: assert property (!wake_ctrl_reg.irq_en |-> !wakeup_irq_out)
        else $error("wakeup request while disabled");
    chk_lv_irq: assert property (lowvolt_irq_out == (lv_flag && lv_ctrl_reg.irq_en))
        else $error("low-voltage request mismatch");
    chk_reset_gate: assert property (chip_reset_out |-> lv_flag && lv_ctrl_reg.reset_en &&
                                     lv_ctrl_reg.detect_en)
        else $error("chip reset without cause");
    chk_write_once: assert property (lv_locked_reg ##0 s_wr_lv |=>
                                     $stable(lv_ctrl_reg.detect_en) && $stable(lv_ctrl_reg.reset_en))
        else $error("write-once bit changed");
    chk_ack_read: assert property (setup_ph && !pwrite_in |=> !prdata_out[6])
        else $error("acknowledge bit read as one");

endmodule : pwl_top

/* File: verif/periodic_wakeup_and_lowvolt_ctrl_tb.sv */
`timescale 1ns/100ps
module periodic_wakeup_and_lowvolt_ctrl_tb;
    logic        clk, nrst, psel, pen, pwr, ext, below, stop, run;
    logic [11:0] paddr;
    logic [31:0] pwd, prd, r;
    logic        rdy, err, e, wirq, lirq, crst, sens, irq;
    int          n_fail, checks, n;
    pwl_top #(.INT_TICK_CYCLES(4)) u_dut (.sys_clk_in(clk), .nrst_in(nrst), .paddr_in(paddr),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd), .pstrb_in(4'hf),
        .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .ext_clk_in(ext),
        .lv_below_in(below), .stop_mode_in(stop), .wakeup_irq_out(wirq),
        .lowvolt_irq_out(lirq), .chip_reset_out(crst), .lv_sense_en_out(sens), .irq_out(irq));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // External timer clock, six system cycles a period, far below the sampling limit
    initial begin
        ext = 0;
        forever begin
            repeat (3) @(posedge clk);
            ext <= run ? ~ext : ext;
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        for (k = 0; k < 50 && rdy !== 1'b1; k++) @(posedge clk);
        // A slave that never answers counts as a mismatch
        if (rdy !== 1'b1) n_fail++;
        r = prd; e = err;
        psel <= 0; pen <= 0;
    endtask : apb
    task automatic t_wake;
        apb(1, pwl_pkg::OFS_MASK, 8'h01);
        apb(1, pwl_pkg::OFS_WAKE, 8'h11);
        for (n = 0; n < 200 && wirq !== 1'b1; n++) @(posedge clk);
        chk(n inside {[58:72]}, 1);
        chk(irq, 1);
        apb(0, pwl_pkg::OFS_WAKE, 8'h00); chk(r, 32'h0000_0091);
        apb(1, pwl_pkg::OFS_WAKE, 8'h01);
        // Request falls at the write edge; look one edge later
        @(posedge clk);
        chk(wirq, 0);
        apb(0, pwl_pkg::OFS_WAKE, 8'h00); chk(r[7], 1);
        apb(1, pwl_pkg::OFS_WAKE, 8'h41);
        apb(0, pwl_pkg::OFS_WAKE, 8'h00); chk(r, 32'h0000_0001);
        apb(1, pwl_pkg::OFS_STS, 8'h01);
        @(posedge clk);
        chk(irq, 0);
        $display("wakeup internal test done");
    endtask : t_wake
    task automatic t_ext;
        run <= 1;
        apb(1, pwl_pkg::OFS_WAKE, 8'h20);
        repeat (2000) @(posedge clk);
        apb(0, pwl_pkg::OFS_WAKE, 8'h00); chk(r, 32'h0000_0020);
        apb(1, pwl_pkg::OFS_WAKE, 8'h31);
        for (n = 0; n < 2000 && wirq !== 1'b1; n++) @(posedge clk);
        chk(n inside {[1520:1560]}, 1);
        apb(0, pwl_pkg::OFS_WAKE, 8'h00); chk(r, 32'h0000_00B1);
        apb(1, pwl_pkg::OFS_WAKE, 8'h40); run <= 0;
        $display("wakeup external test done");
    endtask : t_ext
    task automatic t_lv;
        apb(0, pwl_pkg::OFS_LV, 8'h00); chk(r, 32'h0000_0000);
        apb(1, pwl_pkg::OFS_LV, 8'h34);
        below <= 1;
        for (n = 0; n < 20 && lirq !== 1'b1; n++) @(posedge clk);
        chk(lirq, 1);
        chk(crst, 1);
        apb(0, pwl_pkg::OFS_LV, 8'h00); chk(r, 32'h0000_00B4);
        apb(1, pwl_pkg::OFS_LV, 8'h68);
        apb(0, pwl_pkg::OFS_LV, 8'h00); chk(r, 32'h0000_00B4);
        below <= 0;
        repeat (4) @(posedge clk);
        apb(1, pwl_pkg::OFS_LV, 8'h40);
        apb(0, pwl_pkg::OFS_LV, 8'h00); chk(r, 32'h0000_0014);
        chk(lirq, 0);
        chk(crst, 0);
        chk(sens, 1);
        stop <= 1;
        repeat (3) @(posedge clk);
        chk(sens, 0);
        apb(0, 12'h010, 8'h00); chk(e, 1);
        $display("low-voltage test done");
    endtask : t_lv
    // Mid-run reset unlocks the write-once bits; then detect in stop with stop enable
    task automatic t_rst;
        nrst <= 0;
        repeat (2) @(posedge clk);
        chk(irq, 0);
        chk(lirq, 0);
        nrst <= 1;
        repeat (3) @(posedge clk);
        apb(0, pwl_pkg::OFS_WAKE, 8'h00); chk(r, 32'h0000_0000);
        apb(1, pwl_pkg::OFS_LV, 8'h0C);
        repeat (2) @(posedge clk);
        chk(sens, 1);
        below <= 1;
        repeat (5) @(posedge clk);
        apb(0, pwl_pkg::OFS_LV, 8'h00); chk(r, 32'h0000_008C);
        chk(crst, 0);
        chk(lirq, 0);
        below <= 0;
        stop <= 0;
        $display("reset and stop test done");
    endtask : t_rst
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Watchdog sized well above the total expected run
    initial begin
        #(20 * 20000);
        n_fail++;
        close_out();
    end
    initial begin
        nrst = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwd = 0;
        below = 0; stop = 0; run = 0; n_fail = 0; checks = 0;
        repeat (6) @(posedge clk);
        nrst <= 1;
        repeat (3) @(posedge clk);
        t_wake();
        t_ext();
        t_lv();
        t_rst();
        close_out();
    end
endmodule : periodic_wakeup_and_lowvolt_ctrl_tb
